// >>> logic/rss_defines.vh
// Constants for the remote engine start/stop controller
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH
`define RSS_CLK_HZ 50000000
`define RSS_TICK_US 10000
`define RSS_TICK_CYC ((`RSS_CLK_HZ / 1000000) * `RSS_TICK_US)
`define RSS_DEB_TICKS 2
`define RSS_CRANK_DEF 7'h32
`define RSS_CRANK_MIN 7'h0A
`define RSS_CRANK_MAX 7'h64
`define RSS_PUMP_DEF 12'h01F4
`define RSS_BRIEF_TICKS 8'h64
`define RSS_ADDR_CTRL 4'h0
`define RSS_ADDR_CRANK 4'h1
`define RSS_ADDR_PUMP 4'h2
`define RSS_ADDR_STAT 4'h3
`define RSS_CTRL_PTO 0
`define RSS_CTRL_PUMPMODE 1
`endif

// >>> logic/rss_debounce.v
// Synchroniser and tick-based debouncer for the request switch
module rss_debounce #(
    parameter TICKS = 2
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_i,
    // Tick and raw level
    input wire tick_i,
    input wire raw_i,
    // Filtered level
    output reg clean_o
);
    reg s1_q;
    reg s2_q;
    reg [3:0] cnt_q;

    // Two-stage synchroniser; s1 only feeds s2
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= raw_i;
            s2_q <= s1_q;
        end
    end

    // Accept a new level only once it stays stable over several ticks
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            clean_o <= 1'b0;
        end else if (s2_q == clean_o) begin
            cnt_q <= 4'h0;
        end else if (tick_i) begin
            if (cnt_q == TICKS[3:0] - 4'h1) begin
                clean_o <= s2_q;
                cnt_q <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// >>> logic/rss_ctrl.v
// Remote engine start/stop controller with optional emergency pump mode
`include "rss_defines.vh"

// Summary of operation
// - Requests ignored unless park brake set, hood closed, transmission in neutral.
// - Request line is active low; a grounded line means switch pressed.
// - With PTO interlock enabled, act only while PTO switch on; default off.
// - Wait programmable crank delay, default 0.5 s, 0.1 s to 1 s.
// - While running, a brief switch press commands engine stop.
// - While stopped, crank as long as switch held until engine runs.
// - Operation requires ignition key in on position.
// - Configuration selects plain start/stop or added emergency pump mode.
// - Pump mode: after unexpected stall, pump on after hold time held.
// - Pump mode: switch held after remote stop starts pump after hold time.
// - Pump mode: after failed start, release then hold again to get pump after hold time.
// - Pump control output is active low.
// - Pump stays on exactly while switch stays active.
module rss_ctrl #(
    parameter TICK_CYC = `RSS_TICK_CYC,
    parameter DEB_TICKS = `RSS_DEB_TICKS
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_i,
    // Switch and interlocks
    input wire start_stop_request_line_n_i,
    input wire park_brake_i,
    input wire hood_closed_i,
    input wire trans_neutral_i,
    input wire ign_on_i,
    input wire pto_switch_i,
    input wire engine_running_i,
    // Register port
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    // Engine and pump outputs
    output reg crank_o,
    output reg stop_o,
    output reg pump_control_line_n_o
);
    // Sequencer states: DELAY and CRANK are the start path, HOLD and PUMP the
    // emergency path, WAIT_REL keeps a held switch from retriggering
    localparam ST_IDLE = 3'h0;
    localparam ST_DELAY = 3'h1;
    localparam ST_CRANK = 3'h2;
    localparam ST_RUN = 3'h3;
    localparam ST_STOP = 3'h4;
    localparam ST_WAIT_REL = 3'h5;
    localparam ST_HOLD = 3'h6;
    localparam ST_PUMP = 3'h7;

    reg [2:0] state_q;
    reg [21:0] div_q;
    reg tick_q;
    reg pto_interlock_enable_q;
    reg pump_mode_q;
    reg [6:0] crank_delay_time_q;
    reg [11:0] pump_hold_time_q;
    reg [11:0] tmr_q;
    reg req_prev_q;
    reg stalled_q;
    reg failed_q;
    wire req_raw;
    wire req;
    wire permit;
    wire req_rise;
    wire req_fall;
    wire chassis_ok;
    wire key_ok;
    wire pto_ok;
    wire [15:0] status_word;
    reg [6:0] crank_wr_val;
    reg crank_d;
    reg stop_d;
    reg pump_n_d;

    // Active-low request line inverted to a pressed level
    assign req_raw = ~start_stop_request_line_n_i;

    // Debouncer runs on the same tick as the timers
    rss_debounce #(
        .TICKS(DEB_TICKS)
    ) u_deb (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .tick_i(tick_q),
        .raw_i(req_raw),
        .clean_o(req)
    );

    // Chassis interlocks: brake set, hood shut, transmission in neutral
    assign chassis_ok = park_brake_i & hood_closed_i & trans_neutral_i;
    // Key must sit in the on position
    assign key_ok = ign_on_i;
    // PTO switch only counts once its interlock setting is on
    assign pto_ok = ~pto_interlock_enable_q | pto_switch_i;
    // One permit gates every request; losing it also ends cranking
    assign permit = chassis_ok & key_ok & pto_ok;
    assign req_rise = req & ~req_prev_q;
    assign req_fall = ~req & req_prev_q;

    // Status word: stalled, failed start, request, permit, spare, state
    assign status_word = {8'h00, stalled_q, failed_q, req, permit, 1'b0, state_q};

    // 10 ms tick divider for the timers
    // One free-running divider: timer starts carry up to one tick of jitter
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 22'h00_0000;
            tick_q <= 1'b0;
        end else if (div_q == TICK_CYC[21:0] - 22'h00_0001) begin
            div_q <= 22'h00_0000;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 22'h00_0001;
            tick_q <= 1'b0;
        end
    end

    // Clamp a written crank delay into range; any upper bit set means too long
    always @* begin
        if (wdata_i[15:7] != 9'h000) begin
            crank_wr_val = `RSS_CRANK_MAX;
        end else if (wdata_i[6:0] < `RSS_CRANK_MIN) begin
            crank_wr_val = `RSS_CRANK_MIN;
        end else if (wdata_i[6:0] > `RSS_CRANK_MAX) begin
            crank_wr_val = `RSS_CRANK_MAX;
        end else begin
            crank_wr_val = wdata_i[6:0];
        end
    end

    // Configuration registers; crank delay clamped to its legal range
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pto_interlock_enable_q <= 1'b0; // Defaults to disabled
            pump_mode_q <= 1'b0;
            crank_delay_time_q <= `RSS_CRANK_DEF;
            pump_hold_time_q <= `RSS_PUMP_DEF;
        end else if (wr_i) begin
            case (addr_i)
                `RSS_ADDR_CTRL: begin
                    pto_interlock_enable_q <= wdata_i[`RSS_CTRL_PTO];
                    pump_mode_q <= wdata_i[`RSS_CTRL_PUMPMODE];
                end
                `RSS_ADDR_CRANK: begin
                    crank_delay_time_q <= crank_wr_val;
                end
                `RSS_ADDR_PUMP: begin
                    pump_hold_time_q <= wdata_i[11:0];
                end
                default: begin
                    // Status and unmapped addresses ignore writes
                end
            endcase
        end
    end

    // Read data valid the cycle after the strobe; unmapped reads zero
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `RSS_ADDR_CTRL: rdata_o <= {14'h0000, pump_mode_q, pto_interlock_enable_q};
                `RSS_ADDR_CRANK: rdata_o <= {9'h000, crank_delay_time_q};
                `RSS_ADDR_PUMP: rdata_o <= {4'h0, pump_hold_time_q};
                `RSS_ADDR_STAT: rdata_o <= status_word;
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // Main sequencer; timers advance on the tick only
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            tmr_q <= 12'h000;
            req_prev_q <= 1'b0;
            stalled_q <= 1'b0;
            failed_q <= 1'b0;
        end else begin
            req_prev_q <= req;
            case (state_q)
                ST_IDLE: begin
                    tmr_q <= 12'h000;
                    if (req_rise && permit) begin
                        // Armed stall or failed start routes to pump hold
                        if (pump_mode_q && (stalled_q || failed_q)) begin
                            state_q <= ST_HOLD;
                        end else if (engine_running_i) begin
                            state_q <= ST_RUN;
                        end else begin
                            state_q <= ST_DELAY;
                        end
                    end else if (engine_running_i) begin
                        stalled_q <= 1'b0;
                        failed_q <= 1'b0;
                        state_q <= ST_RUN;
                    end
                end
                ST_DELAY: begin
                    // Release or a lost interlock here counts as a failed start
                    if (!req || !permit) begin
                        failed_q <= 1'b1; // Released before running
                        state_q <= ST_IDLE;
                    end else if (tick_q) begin
                        if (tmr_q == {5'h00, crank_delay_time_q} - 12'h001) begin
                            tmr_q <= 12'h000;
                            state_q <= ST_CRANK;
                        end else begin
                            tmr_q <= tmr_q + 12'h001;
                        end
                    end
                end
                ST_CRANK: begin
                    // Crank until the engine runs or the switch is let go
                    if (engine_running_i) begin
                        failed_q <= 1'b0;
                        stalled_q <= 1'b0;
                        state_q <= ST_WAIT_REL;
                    end else if (!req || !permit) begin
                        failed_q <= 1'b1; // Release ends cranking
                        state_q <= ST_IDLE;
                    end
                end
                ST_RUN: begin
                    // Any engine stop not commanded here counts as a stall
                    if (!engine_running_i) begin
                        stalled_q <= 1'b1; // Unexpected shut-off
                        state_q <= ST_IDLE;
                    end else if (req_rise && permit) begin
                        state_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    // Stop once the engine reports off
                    if (!engine_running_i) begin
                        stalled_q <= 1'b0;
                        tmr_q <= 12'h000;
                        if (req && pump_mode_q) begin
                            state_q <= ST_HOLD;
                        end else begin
                            state_q <= ST_WAIT_REL;
                        end
                    end
                end
                ST_WAIT_REL: begin
                    // Held switch after start or stop must not retrigger
                    if (!req) begin
                        state_q <= engine_running_i ? ST_RUN : ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    // A hold time of zero behaves as one tick
                    if (!req || !permit) begin
                        tmr_q <= 12'h000;
                        state_q <= ST_IDLE;
                    end else if (tick_q) begin
                        if (tmr_q + 12'h001 >= pump_hold_time_q) begin
                            state_q <= ST_PUMP;
                        end else begin
                            tmr_q <= tmr_q + 12'h001;
                        end
                    end
                end
                ST_PUMP: begin
                    if (req_fall || !req) begin
                        tmr_q <= 12'h000;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Next values of the engine and pump drives
    always @* begin
        crank_d = (state_q == ST_CRANK) && req && permit && !engine_running_i;
        stop_d = (state_q == ST_STOP);
        pump_n_d = !((state_q == ST_PUMP) && req);
    end

    // Registered engine and pump drives; pump line pulled low when on
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            crank_o <= 1'b0;
            stop_o <= 1'b0;
            pump_control_line_n_o <= 1'b1;
        end else begin
            crank_o <= crank_d;
            stop_o <= stop_d;
            pump_control_line_n_o <= pump_n_d;
        end
    end
endmodule

// >>> tb/rss_ctrl_chk.sv
// Port checker for the remote start/stop controller
module rss_ctrl_chk #(
    parameter int TICK_CYC = 10
) (
    input wire mclk_i,
    input wire rst_i,
    input wire start_stop_request_line_n_i,
    input wire park_brake_i,
    input wire hood_closed_i,
    input wire trans_neutral_i,
    input wire ign_on_i,
    input wire engine_running_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    input wire crank_o,
    input wire stop_o,
    input wire pump_control_line_n_o
);
    localparam int REL_MAX = 6 * TICK_CYC;
    logic [15:0] held_q;
    wire permit = park_brake_i & hood_closed_i & trans_neutral_i & ign_on_i;
    // Cycles the request line has been grounded, saturating
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i || start_stop_request_line_n_i) begin
            held_q <= 16'h0000;
        end else if (held_q != 16'hFFFF) begin
            held_q <= held_q + 16'h0001;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_crank_permit: assert property ($rose(crank_o) |-> $past(permit))
        else $error("crank without interlocks");
    a_crank_delay: assert property ($rose(crank_o) |-> held_q >= 16'(10 * TICK_CYC))
        else $error("crank came too early");
    a_crank_held: assert property (crank_o && !start_stop_request_line_n_i
        && !engine_running_i && permit |=> crank_o || engine_running_i)
        else $error("crank dropped while held");
    a_crank_ends: assert property (engine_running_i && crank_o |-> ##[1:3] !crank_o)
        else $error("crank kept after start");
    a_stop_cause: assert property ($rose(stop_o) |-> $past(engine_running_i))
        else $error("stop without running engine");
    a_stop_ends: assert property (!engine_running_i && stop_o |-> ##[1:3] !stop_o)
        else $error("stop kept after engine off");
    a_pump_hold: assert property ($fell(pump_control_line_n_o)
        |-> !start_stop_request_line_n_i && held_q > 16'(TICK_CYC))
        else $error("pump without held switch");
    a_pump_release: assert property ($rose(start_stop_request_line_n_i)
        |-> ##[1:REL_MAX] pump_control_line_n_o)
        else $error("pump kept after release");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside its cycle");
    c_crank: cover property ($rose(crank_o));
    c_stop: cover property ($rose(stop_o));
    c_pump: cover property ($fell(pump_control_line_n_o));
endmodule

bind rss_ctrl rss_ctrl_chk #(.TICK_CYC(TICK_CYC)) i_chk (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_stop_request_line_n_i(start_stop_request_line_n_i),
    .park_brake_i(park_brake_i),
    .hood_closed_i(hood_closed_i),
    .trans_neutral_i(trans_neutral_i),
    .ign_on_i(ign_on_i),
    .engine_running_i(engine_running_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .crank_o(crank_o),
    .stop_o(stop_o),
    .pump_control_line_n_o(pump_control_line_n_o)
);

// >>> tb/rss_switch_model.sv
// Ground-active request switch and engine stand-in
module rss_switch_model (
    input wire logic mclk_i,
    input wire logic press_i,
    input wire logic can_start_i,
    input wire logic kill_i,
    input wire logic crank_i,
    input wire logic stop_i,
    output logic req_n_o,
    output logic running_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int crank_cnt = 0;
    initial running_o = 1'b0;
    // Open switch rests at the pull-up, pressed grounds it
    assign req_n_o = press_i ? 1'b0 : 1'b1;
    // Engine catches after 30 cranking cycles unless it cannot
    always @(posedge mclk_i) begin
        crank_cnt <= crank_i ? crank_cnt + 1 : 0;
        if (stop_i || kill_i) begin
            running_o <= 1'b0;
        end else if (crank_cnt == 30 && can_start_i) begin
            running_o <= 1'b1;
        end
    end
endmodule

// >>> tb/rss_ctrl_bench.sv
// Self-checking bench for the remote start/stop controller
module rss_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic press = 1'b0;
    logic can_start = 1'b1;
    logic kill = 1'b0;
    logic pto = 1'b0;
    logic [3:0] ilock = 4'hF;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic req_n, running, crank, stop, pump_n;
    int fails = 0;
    int comparisons = 0;

    rss_switch_model i_sw (.mclk_i(mclk_i), .press_i(press), .can_start_i(can_start),
        .kill_i(kill), .crank_i(crank), .stop_i(stop), .req_n_o(req_n), .running_o(running));
    rss_ctrl #(.TICK_CYC(10), .DEB_TICKS(2)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .start_stop_request_line_n_i(req_n), .park_brake_i(ilock[0]),
        .hood_closed_i(ilock[1]), .trans_neutral_i(ilock[2]), .ign_on_i(ilock[3]),
        .pto_switch_i(pto), .engine_running_i(running), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .crank_o(crank), .stop_o(stop),
        .pump_control_line_n_o(pump_n));

    initial forever #10 mclk_i = ~mclk_i;

    task automatic test_done;
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(logic [3:0] a, logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        // Idle edge so a following write never re-raises wr in this step
        @(posedge mclk_i);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(logic [3:0] a, logic [15:0] exp, string name);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 check(name, rdata, exp);
        @(posedge mclk_i);
    endtask

    function automatic logic seen(int sel);
        case (sel)
            0: return crank;
            1: return !pump_n;
            2: return stop;
            default: return pump_n;
        endcase
    endfunction

    // Hold the switch and time the chosen output, bounded
    task automatic attempt(int sel, int lim, int lo, int hi, string name);
        int n;
        n = 0;
        // Watching for the pump to let go means releasing the switch
        press <= (sel != 3);
        while (n < lim && seen(sel) !== 1'b1) begin
            @(posedge mclk_i);
            n++;
        end
        check(name, 16'(n >= lo && n <= hi), 16'h0001);
    endtask

    task automatic let_go(int n);
        press <= 1'b0;
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic start_engine;
        attempt(0, 400, 100, 160, "crank delay");
        repeat (40) @(posedge mclk_i);
        check("started", 16'({running, crank}), 16'h0002);
        let_go(60);
    endtask

    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd_reg(4'h0, 16'h0000, "ctrl reset");
        rd_reg(4'h1, 16'h0032, "crank reset");
        rd_reg(4'h2, 16'h01F4, "hold reset");
        rd_reg(4'hF, 16'h0000, "unmapped");
        rd_reg(4'h3, 16'h0010, "status reset");
        wr_reg(4'h1, 16'h0005);
        rd_reg(4'h1, 16'h000A, "crank min");
        wr_reg(4'h1, 16'h00C8);
        rd_reg(4'h1, 16'h0064, "crank max");
        wr_reg(4'h1, 16'h000A);
        wr_reg(4'h2, 16'h0014);
        wr_reg(4'h0, 16'h0001);
        // Each interlock missing in turn, last pass the PTO switch off
        for (int i = 0; i < 5; i++) begin
            ilock <= (i < 4) ? ~(4'h1 << i) : 4'hF;
            attempt(0, 300, 300, 300, "blocked");
            let_go(40);
        end
        pto <= 1'b1;
        start_engine();
        press <= 1'b1;
        repeat (8) @(posedge mclk_i);
        let_go(100);
        check("glitch", 16'({running, stop}), 16'h0002);
        // Two sync edges, two debounce ticks, then two register stages
        attempt(2, 80, 15, 30, "stop");
        attempt(1, 400, 400, 400, "no pump plain");
        let_go(60);
        wr_reg(4'h0, 16'h0003);
        start_engine();
        attempt(2, 80, 15, 30, "stop");
        attempt(1, 400, 180, 240, "pump after stop");
        repeat (100) @(posedge mclk_i);
        check("pump held", 16'(pump_n), 16'h0000);
        attempt(3, 80, 0, 60, "pump release");
        let_go(60);
        // Failed start first: the failed flag sends the next press to the pump
        can_start <= 1'b0;
        attempt(0, 400, 100, 160, "crank dead engine");
        repeat (100) @(posedge mclk_i);
        check("still cranking", 16'(crank), 16'h0001);
        let_go(60);
        attempt(1, 400, 200, 260, "pump after failed start");
        let_go(60);
        // Plain mode ignores the failed flag, so the engine can start again
        can_start <= 1'b1;
        wr_reg(4'h0, 16'h0001);
        start_engine();
        wr_reg(4'h0, 16'h0003);
        kill <= 1'b1;
        repeat (5) @(posedge mclk_i);
        attempt(1, 400, 200, 260, "pump after stall");
        let_go(60);
        test_done();
    end

    // Whole run needs well under 10000 cycles
    initial begin
        #400000;
        fails++;
        test_done();
    end
endmodule
